// file: core/rcmr_top.sv
// Serially loaded mode registers and their mode controls for the read channel
// Function
// - Four address bits: 0000 selects pulse register, A0 alone selects recovery; rest reserved.
// - Pulse bits 1,2 pick hysteresis source: pin, maximum, nominal or minimum.
// - Pulse bit 3 low drives detected read pulses out on read data pin.
// - Pulse bit 3 high takes external pattern from read data pin into recovery.
// - Recovery bit 0 high disables phase detector so oscillator coasts, test only.
// - Recovery bit 1 high hard sector; low enables 7,7,11,11 address mark logic.
// - Recovery bits 2,3 set precompensation: 11 max, 01 second, 10 min, 00 none.
// - Hard sector floats mark detect; otherwise low mark detect level while read gate.
// - Soft sector with write gate: one-bit low strobe writes the zero-run mark.
`timescale 1ns/1ps
module rcmr_top
  import rcmr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       ce,
  input  wire logic       serial_clk,
  input  wire logic       serial_config_data,
  input  wire logic       serial_latch,
  input  wire logic       write_gate,
  input  wire logic       read_gate,
  input  wire logic       bit_tick,
  input  wire logic       detected_pulse,
  input  wire logic       read_data_in,
  input  wire logic       mark_write_strobe,
  output logic            read_data_out,
  output logic            read_data_oe_n,
  output logic            recovery_data,
  output logic            mark_detect_out,
  output logic            mark_detect_oe_n,
  output logic            write_zero_force,
  output logic            fast_gain_enable,
  output logic            threshold_level_pin_sel,
  output logic [1:0]      hysteresis_fixed,
  output logic            phase_detect_enable,
  output logic [1:0]      precomp_shift,
  output logic [3:0]      pulse_detector_control,
  output logic [3:0]      recovery_control
);
  logic [RCMR_FRAME_W-1:0] shift;
  logic [3:0]              bit_cnt;
  logic                    sclk_q;
  logic                    latch_q;
  logic                    strobe_q;
  logic                    mark_seen;
  logic                    seq_zero;
  logic                    seq_busy;
  logic                    seq_found;
  logic [3:0]              det_cnt;
  logic [1:0]              det_run;

  // Frame bits arrive A0..A3 then D0..D3, so the oldest bit ends lowest
  wire [3:0] frame_addr  = shift[3:0];
  wire [3:0] frame_data  = shift[7:4];
  wire       sclk_rise   = serial_clk & ~sclk_q;
  wire       latch_fall  = latch_q & ~serial_latch;
  wire       frame_full  = (bit_cnt == 4'(RCMR_FRAME_W));
  wire       sel_pulse   = frame_full & (frame_addr == RCMR_ADDR_PULSE);
  wire       sel_recov   = frame_full & (frame_addr == RCMR_ADDR_RECOV);
  wire       hard_sector = recovery_control[RCMR_RC_HARD];
  wire       test_mode   = pulse_detector_control[RCMR_PD_TEST];
  wire       mark_start  = strobe_q & ~mark_write_strobe & write_gate & ~hard_sector & ~seq_busy;
  wire [1:0] hys_code    = {pulse_detector_control[RCMR_PD_HYS_LO], pulse_detector_control[RCMR_PD_HYS_HI]};
  wire [1:0] pc_code     = {recovery_control[RCMR_RC_PC_LO], recovery_control[RCMR_RC_PC_HI]};
  // Code to shift magnitude
  // Codes are not in magnitude order: 01 is the second highest, 10 the smallest
  wire [1:0] next_precomp_shift = (pc_code == 2'h3) ? RCMR_PC_MAXS :
                                  (pc_code == 2'h1) ? RCMR_PC_SECOND :
                                  (pc_code == 2'h2) ? RCMR_PC_MINS : RCMR_PC_NONE;
  wire       data_source = test_mode ? read_data_in : detected_pulse;
  // Bit set turns the fast currents off
  wire       next_fast_gain_enable        = ~pulse_detector_control[RCMR_PD_FAST_OFF];
  wire       next_threshold_level_pin_sel = (hys_code == RCMR_HYS_EXT);
  wire       next_phase_detect_enable     = ~recovery_control[RCMR_RC_COAST];

  // The serial clock is sampled, so each of its phases must span at least one clock
  // Serial capture; a latch fall commits the frame only once all 8 bits have filled
  always_ff @(posedge clk) begin
    if (!rstn) begin
      shift   <= 8'h00;
      bit_cnt <= 4'h0;
      sclk_q  <= 1'b0;
      latch_q <= 1'b0;
    end else if (ce) begin
      sclk_q  <= serial_clk;
      latch_q <= serial_latch;
      if (!serial_latch) begin
        bit_cnt <= 4'h0;
      end else if (sclk_rise && !frame_full) begin
        shift   <= {serial_config_data, shift[7:1]};
        bit_cnt <= bit_cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pulse_detector_control <= RCMR_PULSE_RST;
      recovery_control       <= RCMR_RECOV_RST;
    end else if (ce && latch_fall) begin
      if (sel_pulse) begin
        pulse_detector_control <= frame_data;
      end else if (sel_recov) begin
        recovery_control <= frame_data;
      end
    end
  end

  // Mode outputs decoded from the stored fields
  always_ff @(posedge clk) begin
    if (!rstn) begin
      fast_gain_enable        <= 1'b1;
      threshold_level_pin_sel <= 1'b1;
      hysteresis_fixed        <= 2'h0;
      phase_detect_enable     <= 1'b1;
      precomp_shift           <= RCMR_PC_NONE;
    end else if (ce) begin
      fast_gain_enable        <= next_fast_gain_enable;
      threshold_level_pin_sel <= next_threshold_level_pin_sel;
      hysteresis_fixed        <= hys_code;
      phase_detect_enable     <= next_phase_detect_enable;
      precomp_shift           <= next_precomp_shift;
    end
  end

  // Read data test pin direction and recovery source
  always_ff @(posedge clk) begin
    if (!rstn) begin
      read_data_out  <= 1'b0;
      read_data_oe_n <= 1'b1;
      recovery_data  <= 1'b0;
    end else if (ce) begin
      read_data_out  <= detected_pulse;
      read_data_oe_n <= test_mode;
      recovery_data  <= data_source;
    end
  end

  // Mark detector steps once per bit cell on the recovered bit stream
  wire       det_one      = bit_tick & recovery_data;
  wire       det_zero     = bit_tick & ~recovery_data;
  wire [3:0] det_len      = (det_run < 2'd2) ? RCMR_RUN_SHORT : RCMR_RUN_LONG;
  wire       det_match    = (det_cnt == det_len);
  wire       det_last     = (det_run == 2'(RCMR_RUNS - 1));
  // Saturate so a long gap cannot wrap into a false run length
  wire       det_sat      = (det_cnt == 4'hF);
  wire [3:0] next_det_cnt = det_zero ? (det_sat ? det_cnt : det_cnt + 4'h1) :
                            det_one  ? 4'h0 : det_cnt;
  // A short run that breaks the pattern may still open a new mark
  wire [1:0] det_restart  = (det_cnt == RCMR_RUN_SHORT) ? 2'h1 : 2'h0;
  wire [1:0] next_det_run = !det_one  ? det_run :
                            det_match ? det_run + 2'h1 : det_restart;
  wire       next_found   = det_one & det_match & det_last;
  wire       clear_mark   = ~read_gate | hard_sector;
  wire       next_mark_seen       = clear_mark ? 1'b0 : (mark_seen | seq_found);
  wire       next_mark_detect_out = ~(mark_seen & read_gate & ~hard_sector);

  // Soft sector mark detect; hard sector freezes it as it does the writer
  always_ff @(posedge clk) begin
    if (!rstn) begin
      det_cnt   <= 4'h0;
      det_run   <= 2'h0;
      seq_found <= 1'b0;
    end else if (ce && !hard_sector) begin
      det_cnt   <= next_det_cnt;
      det_run   <= next_det_run;
      seq_found <= next_found;
    end
  end

  // Mark detect holds low until read gate drops, so a short read still shows it
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mark_seen <= 1'b0;
    end else if (ce) begin
      mark_seen <= next_mark_seen;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      strobe_q         <= 1'b1;
      mark_detect_out  <= 1'b1;
      mark_detect_oe_n <= 1'b1;
      write_zero_force <= 1'b0;
    end else if (ce) begin
      strobe_q <= mark_write_strobe;
      // Float in hard sector, active low
      mark_detect_oe_n <= hard_sector;
      mark_detect_out  <= next_mark_detect_out;
      write_zero_force <= seq_zero & write_gate;
    end
  end

  rcmr_mark_seq u_seq (
    .clk      (clk),
    .rstn     (rstn),
    .ce       (ce & ~hard_sector),
    .start    (mark_start),
    .bit_tick (bit_tick),
    .wr_zero  (seq_zero),
    .busy     (seq_busy)
  );
endmodule

// file: core/rcmr_pkg.sv
// Package: register map, field positions and timing for the read channel mode registers
package rcmr_pkg;
  // Serial frame: 4 address bits (A0 first) then 4 data bits (D0 first)
  localparam int unsigned RCMR_ADDR_W     = 4;
  localparam int unsigned RCMR_DATA_W     = 4;
  localparam int unsigned RCMR_FRAME_W    = 8;
  localparam logic [3:0]  RCMR_ADDR_PULSE = 4'h0;
  localparam logic [3:0]  RCMR_ADDR_RECOV = 4'h1;
  localparam logic [3:0]  RCMR_ADDR_RSVD  = 4'h2;
  localparam logic [3:0]  RCMR_PULSE_RST  = 4'h0;
  localparam logic [3:0]  RCMR_RECOV_RST  = 4'h0;
  // Pulse detector fields
  localparam int unsigned RCMR_PD_FAST_OFF = 0;
  localparam int unsigned RCMR_PD_HYS_LO   = 1;
  localparam int unsigned RCMR_PD_HYS_HI   = 2;
  localparam int unsigned RCMR_PD_TEST     = 3;
  // Recovery fields
  localparam int unsigned RCMR_RC_COAST    = 0;
  localparam int unsigned RCMR_RC_HARD     = 1;
  localparam int unsigned RCMR_RC_PC_LO    = 2;
  localparam int unsigned RCMR_RC_PC_HI    = 3;
  // Hysteresis source codes as {D1,D2}
  localparam logic [1:0]  RCMR_HYS_EXT     = 2'h0;
  localparam logic [1:0]  RCMR_HYS_MAX     = 2'h1;
  localparam logic [1:0]  RCMR_HYS_NOM     = 2'h2;
  localparam logic [1:0]  RCMR_HYS_MIN     = 2'h3;
  // Precompensation shift magnitude, 0 none .. 3 maximum
  localparam logic [1:0]  RCMR_PC_NONE     = 2'h0;
  localparam logic [1:0]  RCMR_PC_MINS     = 2'h1;
  localparam logic [1:0]  RCMR_PC_SECOND   = 2'h2;
  localparam logic [1:0]  RCMR_PC_MAXS     = 2'h3;
  // Address mark zero-run lengths in bit cells
  localparam logic [3:0]  RCMR_RUN_SHORT   = 4'h7;
  localparam logic [3:0]  RCMR_RUN_LONG    = 4'hB;
  localparam int unsigned RCMR_RUNS        = 4;
  // Latch setup 1.5 us at 40 ns clock
  localparam int unsigned RCMR_CLK_NS      = 40;
  localparam int unsigned RCMR_TSLAT_NS    = 1500;
  localparam int unsigned RCMR_SLAT_CYC    = (RCMR_TSLAT_NS + RCMR_CLK_NS - 1) / RCMR_CLK_NS;
endpackage

// file: core/rcmr_mark_seq.sv
// Address mark zero-run sequencer for writing
`timescale 1ns/1ps
module rcmr_mark_seq
  import rcmr_pkg::*;
(
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic ce,
  input  wire logic start,
  input  wire logic bit_tick,
  output logic      wr_zero,
  output logic      busy
);
  typedef enum logic [1:0] {RCMR_IDLE, RCMR_RUN, RCMR_ONE} rcmr_seq_e;
  rcmr_seq_e  state;
  logic [3:0] cnt;
  logic [1:0] run;
  wire  [3:0] run_len = (run < 2'd2) ? RCMR_RUN_SHORT : RCMR_RUN_LONG;

  assign wr_zero = (state == RCMR_RUN);
  assign busy    = (state != RCMR_IDLE);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= RCMR_IDLE;
      cnt   <= 4'h0;
      run   <= 2'h0;
    end else if (ce) begin
      case (state)
        RCMR_IDLE: begin
          if (start) begin
            state <= RCMR_RUN;
            cnt   <= 4'h0;
            run   <= 2'h0;
          end
        end
        RCMR_RUN: begin
          if (bit_tick) begin
            if (cnt == run_len - 4'h1) begin
              state <= RCMR_ONE;
            end else begin
              cnt <= cnt + 4'h1;
            end
          end
        end
        RCMR_ONE: begin
          if (bit_tick) begin
            cnt   <= 4'h0;
            run   <= run + 2'h1;
            state <= (run == 2'(RCMR_RUNS - 1)) ? RCMR_IDLE : RCMR_RUN;
          end
        end
        default: state <= RCMR_IDLE;
      endcase
    end
  end
endmodule

// file: verif/rcmr_ctrl_model.sv
// Serial controller model that loads the mode registers
`timescale 1ns/1ps
module rcmr_ctrl_model (
  input  wire logic clk,
  output logic      serial_clk,
  output logic      serial_config_data,
  output logic      serial_latch
);
  initial {serial_clk, serial_config_data, serial_latch} = 3'h0;
  task automatic send(input logic [3:0] a, input logic [3:0] d, input int nbits);
    logic [7:0] fr;
    fr = {d, a};
    @(posedge clk) serial_latch <= 1'b1;
    for (int i = 0; i < nbits; i++) begin
      @(posedge clk) serial_clk <= 1'b0;
      serial_config_data <= fr[i];
      repeat (2) @(posedge clk);
      serial_clk <= 1'b1;
      repeat (2) @(posedge clk);
    end
    @(posedge clk) serial_latch <= 1'b0;
    // Hold time is over, so the old bit must not linger
    serial_config_data <= ~serial_config_data;
    repeat (4) @(posedge clk);
  endtask
endmodule

// file: verif/rcmr_monitor.sv
// Checker of mode outputs and address mark logic
`timescale 1ns/1ps
module rcmr_monitor (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       serial_latch,
  input wire logic       detected_pulse,
  input wire logic       read_data_in,
  input wire logic       write_gate,
  input wire logic       read_gate,
  input wire logic       mark_write_strobe,
  input wire logic       read_data_out,
  input wire logic       read_data_oe_n,
  input wire logic       recovery_data,
  input wire logic       mark_detect_out,
  input wire logic       mark_detect_oe_n,
  input wire logic       write_zero_force,
  input wire logic       fast_gain_enable,
  input wire logic       threshold_level_pin_sel,
  input wire logic [1:0] hysteresis_fixed,
  input wire logic       phase_detect_enable,
  input wire logic [1:0] precomp_shift,
  input wire logic [3:0] pulse_detector_control,
  input wire logic [3:0] recovery_control
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence s_wr_start;
    write_gate && !recovery_control[1] && !write_zero_force && $fell(mark_write_strobe);
  endsequence
  sequence s_first_run;
    write_zero_force [*8];
  endsequence
  AST_REG_COMMIT: assert property ($changed({pulse_detector_control, recovery_control}) |-> !$past(serial_latch))
    else $error("register changed inside a frame");
  AST_FAST_GAIN: assert property (fast_gain_enable == !$past(pulse_detector_control[0]))
    else $error("fast gain enable wrong");
  AST_HYS_SRC: assert property ({threshold_level_pin_sel, hysteresis_fixed} ==
    {$past(pulse_detector_control[2:1]) == 2'h0, $past(pulse_detector_control[1]), $past(pulse_detector_control[2])})
    else $error("hysteresis source wrong");
  AST_RD_DRIVE: assert property ($past(rstn) && !$past(pulse_detector_control[3]) |->
    !read_data_oe_n && read_data_out == $past(detected_pulse))
    else $error("read data pin not driven");
  AST_RD_ROUTE: assert property ($past(rstn) && pulse_detector_control[3] == $past(pulse_detector_control[3], 2) |->
    recovery_data == ($past(pulse_detector_control[3]) ? $past(read_data_in) : $past(detected_pulse)))
    else $error("recovery data source wrong");
  AST_COAST: assert property (phase_detect_enable == !$past(recovery_control[0]))
    else $error("phase detector enable wrong");
  AST_HARD_FLOAT: assert property ($past(recovery_control[1]) |-> mark_detect_oe_n)
    else $error("mark detect driven in hard sector");
  AST_PRECOMP: assert property (precomp_shift == {$past(recovery_control[3]), $past(recovery_control[2])})
    else $error("precomp shift wrong");
  AST_MARK_GATE: assert property (!read_gate ##1 !read_gate |-> mark_detect_out)
    else $error("mark detect active without read gate");
  AST_MARK_WRITE: assert property (s_wr_start |-> ##[1:12] s_first_run)
    else $error("mark write did not start");
endmodule

// file: verif/read_channel_mode_registers_tb_top.sv
// Self-checking bench for the read channel mode registers
`timescale 1ns/1ps
module read_channel_mode_registers_tb_top import rcmr_pkg::*;;
  typedef struct packed {logic [3:0] a; logic [3:0] d; logic [3:0] pd; logic [3:0] rc; logic [6:0] m;} rcmr_row_s;
  logic       clk = 1'b0, rstn = 1'b0, ce = 1'b1, write_gate = 1'b0, read_gate = 1'b0, bit_tick = 1'b0;
  logic       detected_pulse = 1'b0, read_data_in = 1'b0, mark_write_strobe = 1'b1;
  logic       serial_clk, serial_config_data, serial_latch, read_data_out, read_data_oe_n, recovery_data;
  logic       mark_detect_out, mark_detect_oe_n, write_zero_force, fast_gain_enable, threshold_level_pin_sel;
  logic       phase_detect_enable;
  logic [1:0] hysteresis_fixed, precomp_shift, tc = 2'h0;
  logic [3:0] pulse_detector_control, recovery_control;
  logic [7:0] modes;
  int         miscompares = 0, cmp_count = 0, cyc = 0, n;
  rcmr_row_s  rows [10] = '{{RCMR_ADDR_PULSE, 4'h1, 4'h1, 4'h0, 7'h24}, {RCMR_ADDR_PULSE, 4'h2, 4'h2, 4'h0, 7'h54},
    {RCMR_ADDR_PULSE, 4'h4, 4'h4, 4'h0, 7'h4C}, {RCMR_ADDR_PULSE, 4'h6, 4'h6, 4'h0, 7'h5C},
    {RCMR_ADDR_RECOV, 4'h1, 4'h6, 4'h1, 7'h58}, {RCMR_ADDR_RECOV, 4'h4, 4'h6, 4'h4, 7'h5D},
    {RCMR_ADDR_RECOV, 4'h8, 4'h6, 4'h8, 7'h5E}, {RCMR_ADDR_RECOV, 4'hC, 4'h6, 4'hC, 7'h5F},
    {RCMR_ADDR_RSVD, 4'hF, 4'h6, 4'hC, 7'h5F}, {4'hF, 4'h0, 4'h6, 4'hC, 7'h5F}};
  assign modes = {1'b0, fast_gain_enable, threshold_level_pin_sel, hysteresis_fixed, phase_detect_enable, precomp_shift};
  rcmr_top dut_u (.clk, .rstn, .ce, .serial_clk, .serial_config_data, .serial_latch, .write_gate, .read_gate,
    .bit_tick, .detected_pulse, .read_data_in, .mark_write_strobe, .read_data_out, .read_data_oe_n, .recovery_data,
    .mark_detect_out, .mark_detect_oe_n, .write_zero_force, .fast_gain_enable, .threshold_level_pin_sel,
    .hysteresis_fixed, .phase_detect_enable, .precomp_shift, .pulse_detector_control, .recovery_control);
  rcmr_ctrl_model ctl_u (.clk, .serial_clk, .serial_config_data, .serial_latch);
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Strobe low for one bit cell, count cycles of forced zeros
  task automatic strobe_mark(output int cnt);
    cnt = 0;
    for (int k = 0; k < 200; k++) begin
      @(posedge clk);
      mark_write_strobe <= (k > 3);
      cnt += int'(write_zero_force === 1'b1);
    end
  endtask
  // Read pattern: each run of zeros ends in a one, one bit per bit cell
  task automatic send_mark;
    for (int r = 0; r < 4; r++) begin
      for (int b = 0; b <= ((r < 2) ? 7 : 11); b++) begin
        @(posedge clk iff bit_tick);
        read_data_in <= (b == ((r < 2) ? 7 : 11));
      end
    end
  endtask
  always @(posedge clk) begin
    tc <= tc + 2'h1;
    bit_tick <= (tc == 2'h3);
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      report_and_stop();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    #1 check({pulse_detector_control, recovery_control}, 8'h00, "reset regs");
    check({modes[6], mark_detect_oe_n, read_data_oe_n}, 8'h07, "reset outs");
    rstn <= 1'b1;
    foreach (rows[i]) begin
      ctl_u.send(rows[i].a, rows[i].d, 8);
      #1 check({pulse_detector_control, recovery_control}, {rows[i].pd, rows[i].rc}, "regs");
      check(modes, {1'b0, rows[i].m}, "modes");
    end
    $display("Table test done");
    ctl_u.send(RCMR_ADDR_PULSE, 4'h9, 6);
    #1 check({pulse_detector_control, recovery_control}, 8'h6C, "short frame");
    ctl_u.send(RCMR_ADDR_PULSE, 4'h8, 8);
    {read_data_in, detected_pulse} <= 2'b10;
    repeat (3) @(posedge clk);
    #1 check({read_data_oe_n, recovery_data}, 8'h03, "test path");
    ctl_u.send(RCMR_ADDR_PULSE, 4'h0, 8);
    {read_data_in, detected_pulse} <= 2'b01;
    repeat (3) @(posedge clk);
    #1 check({read_data_oe_n, read_data_out, recovery_data}, 8'h03, "normal path");
    $display("Read data test done");
    write_gate <= 1'b1;
    strobe_mark(n);
    // 36 zero cells of 4 clocks; the strobe lands 1 clock before a cell edge
    check(n[7:0], 8'h8D, "soft mark zero cycles");
    ctl_u.send(RCMR_ADDR_RECOV, 4'h2, 8);
    strobe_mark(n);
    #1 check({n[6:0], mark_detect_oe_n}, 8'h01, "hard sector");
    $display("Mark write test done");
    write_gate <= 1'b0;
    read_data_in <= 1'b1;
    ctl_u.send(RCMR_ADDR_RECOV, 4'h0, 8);
    ctl_u.send(RCMR_ADDR_PULSE, 4'h8, 8);
    read_gate <= 1'b1;
    repeat (8) @(posedge clk);
    send_mark();
    repeat (8) @(posedge clk);
    #1 check({mark_detect_oe_n, mark_detect_out}, 8'h00, "mark found");
    read_gate <= 1'b0;
    repeat (3) @(posedge clk);
    #1 check({mark_detect_oe_n, mark_detect_out}, 8'h01, "mark released");
    $display("Mark detect test done");
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    #1 check({pulse_detector_control, recovery_control}, 8'h00, "second reset");
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    #1 check(modes, 8'h64, "modes after reset");
    $display("Reset test done");
    report_and_stop();
  end
endmodule
bind rcmr_top rcmr_monitor mon_u (.clk, .rstn, .serial_latch, .detected_pulse, .read_data_in, .write_gate,
  .read_gate, .mark_write_strobe, .read_data_out, .read_data_oe_n, .recovery_data, .mark_detect_out,
  .mark_detect_oe_n, .write_zero_force, .fast_gain_enable, .threshold_level_pin_sel, .hysteresis_fixed,
  .phase_detect_enable, .precomp_shift, .pulse_detector_control, .recovery_control);
